// *** shared/flash_pins_pkg.sv ***
// Purpose: shared constants for the serial flash pin and array-control block
// Assumes: 17-bit array address, byte-wide array port
// Notes:   opcodes, erase kinds, alignment masks and state codes live here
package flash_pins_pkg;

  // Array geometry
  localparam int          ADDR_W     = 17;
  localparam logic [16:0] ARRAY_LAST = 17'h1ffff;
  localparam logic [16:0] MASK_4K    = 17'h00fff;
  localparam logic [16:0] MASK_32K   = 17'h07fff;
  localparam logic [16:0] MASK_CHIP  = 17'h1ffff;
  localparam logic [16:0] MASK_PAGE  = 17'h000ff;

  // Opcodes
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_FAST = 8'h0b;
  localparam logic [7:0] OP_READ_DUAL = 8'h3b;
  localparam logic [7:0] OP_PROGRAM   = 8'h02;
  localparam logic [7:0] OP_ERASE_4K  = 8'h20;
  localparam logic [7:0] OP_ERASE_32A = 8'h52;
  localparam logic [7:0] OP_ERASE_32B = 8'hd8;
  localparam logic [7:0] OP_CHIP_A    = 8'h60;
  localparam logic [7:0] OP_CHIP_B    = 8'hc7;
  localparam logic [7:0] OP_CHIP_C    = 8'h62;

  // Erase granularity codes
  localparam logic [1:0] ERASE_4K   = 2'h0;
  localparam logic [1:0] ERASE_32K  = 2'h1;
  localparam logic [1:0] ERASE_CHIP = 2'h2;

  // Pin sampler bit positions and reset (idle) levels
  localparam int         PIN_CS   = 4;
  localparam int         PIN_SCK  = 3;
  localparam int         PIN_SI   = 2;
  localparam int         PIN_WP   = 1;
  localparam int         PIN_HOLD = 0;
  localparam logic [4:0] PIN_IDLE = 5'h17;

  // Self-timed program/erase length in MCLK cycles
  localparam int BUSY_CYCLES_DEF = 1000;

  typedef enum logic [5:0] {
    ST_CMD    = 6'h01,
    ST_ADDR   = 6'h02,
    ST_DUMMY  = 6'h04,
    ST_READ   = 6'h08,
    ST_PROG   = 6'h10,
    ST_IGNORE = 6'h20
  } state_t;

endpackage

// *** design/pin_sampler.sv ***
// Purpose: two-flop synchroniser with edge detect for asynchronous pins
// Assumes: one MCLK domain
// Notes:   reset value models the idle (pulled) level of each pin
`timescale 1ns/1ps
module pin_sampler #(
  parameter int         W       = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Raw pins and sampled results
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // First stage feeds only the second; edges compare stages two and three
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta  <= RST_VAL;
      level <= RST_VAL;
      prev  <= RST_VAL;
    end
    else
    begin
      meta  <= raw;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule // pin_sampler

// *** design/flash_pins_core.sv ***
// Purpose: pin-level serial engine of a small serial flash with array control
// Assumes: SCK, CS_N, SI, WP_N, HOLD_N are asynchronous to MCLK, SCK <= MCLK/8
// Notes:   array storage sits outside; this block issues reads, writes, erases
`timescale 1ns/1ps
module flash_pins_core
  import flash_pins_pkg::*;
#(
  parameter int BUSY_CYCLES = flash_pins_pkg::BUSY_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                          MCLK,
  input  wire logic                          RSTN,
  // Serial pins
  input  wire logic                          CS_N,
  input  wire logic                          SCK,
  input  wire logic                          SI,
  input  wire logic                          WP_N,
  input  wire logic                          HOLD_N,
  output logic                               SO,
  output logic                               SO_OE,
  output logic                               DUAL_DATA_LOWER_BIT,
  output logic                               DUAL_DATA_LOWER_BIT_OE,
  // Array port
  output logic [flash_pins_pkg::ADDR_W-1:0]  ARR_RD_ADDR,
  input  wire logic [7:0]                    ARR_RD_DATA,
  output logic                               ARR_WR,
  output logic [flash_pins_pkg::ADDR_W-1:0]  ARR_WR_ADDR,
  output logic [7:0]                         ARR_WR_DATA,
  output logic                               ARR_ERASE,
  output logic [1:0]                         ARR_ERASE_KIND,
  output logic [flash_pins_pkg::ADDR_W-1:0]  ARR_ERASE_ADDR,
  // Status
  output logic                               BUSY,
  output logic                               STANDBY
);
  import flash_pins_pkg::*;

  localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [4:0] pin_level;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  // Idle levels high on hold and write protect stand in for the pull-ups
  pin_sampler #(.W(5), .RST_VAL(PIN_IDLE)) u_pins (
    .clk   (MCLK),
    .rst_n (RSTN),
    .raw   ({CS_N, SCK, SI, WP_N, HOLD_N}),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  wire cs_act   = ~pin_level[PIN_CS];
  wire cs_start = pin_fall[PIN_CS];
  wire cs_end   = pin_rise[PIN_CS];
  wire hold_act = cs_act & ~pin_level[PIN_HOLD];
  wire run      = cs_act & ~hold_act;
  wire sck_rise = pin_rise[PIN_SCK] & run;
  wire sck_fall = pin_fall[PIN_SCK] & run;
  wire si_bit   = pin_level[PIN_SI];
  wire wp_lock  = ~pin_level[PIN_WP];

  //////////////////////////////////////////////////////////////////////////////
  // Engine state

  state_t              state;
  logic [7:0]          opcode;
  logic [7:0]          shreg;
  logic [2:0]          bitcnt;
  logic [1:0]          bytecnt;
  logic [ADDR_W-1:0]   addr;
  logic [7:0]          outbuf;
  logic [7:0]          pofs;
  logic                dual;
  logic                pend_erase;
  logic [1:0]          pend_kind;
  logic                prog_seen;
  logic [BUSY_W-1:0]   busy_cnt;

  // Classify the erase opcode for the array bookkeeping
  function automatic logic [1:0] erase_kind(input logic [7:0] op);
    if (op == OP_ERASE_4K)
      return ERASE_4K;
    else if (op == OP_ERASE_32A || op == OP_ERASE_32B)
      return ERASE_32K;
    else
      return ERASE_CHIP;
  endfunction

  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                              input logic [1:0] kind);
    if (kind == ERASE_4K)
      return a & ~MASK_4K;
    else if (kind == ERASE_32K)
      return a & ~MASK_32K;
    else
      return a & ~MASK_CHIP;
  endfunction

  wire [7:0] byte_in   = {shreg[6:0], si_bit};
  wire       byte_done = sck_rise & (bitcnt == 3'h7);
  wire       is_read   = byte_in == OP_READ_SLOW || byte_in == OP_READ_FAST
                         || byte_in == OP_READ_DUAL;
  wire       is_addr_wr = byte_in == OP_PROGRAM || byte_in == OP_ERASE_4K
                          || byte_in == OP_ERASE_32A || byte_in == OP_ERASE_32B;
  wire       is_chip   = byte_in == OP_CHIP_A || byte_in == OP_CHIP_B
                         || byte_in == OP_CHIP_C;
  wire       busy_now  = busy_cnt != '0;
  // Writes are refused up front when locked or when the array is still busy
  wire       wr_ok     = ~wp_lock & ~busy_now;
  wire [ADDR_W-1:0] next_addr = {addr[ADDR_W-9:0], byte_in};
  wire [7:0] cur_byte  = (bitcnt == 3'h0) ? ARR_RD_DATA : outbuf;
  wire       rd_last   = dual ? (bitcnt == 3'h6) : (bitcnt == 3'h7);

  //////////////////////////////////////////////////////////////////////////////
  // Command, address and data capture

  // Hold freezes the bit and byte counters simply because no edge gets through
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state   <= ST_CMD;
      opcode  <= 8'h00;
      shreg   <= 8'h00;
      bitcnt  <= 3'h0;
      bytecnt <= 2'h0;
      addr    <= '0;
      dual    <= 1'b0;
    end
    else if (cs_start || cs_end)
    begin
      state   <= ST_CMD;
      bitcnt  <= 3'h0;
      bytecnt <= 2'h0;
      dual    <= 1'b0;
    end
    else if (sck_rise && state != ST_READ && state != ST_IGNORE)
    begin
      shreg  <= byte_in;
      bitcnt <= bitcnt + 3'h1;
      if (byte_done)
      begin
        case (state)
          ST_CMD:
          begin
            opcode <= byte_in;
            dual   <= byte_in == OP_READ_DUAL;
            if (is_read && !busy_now)
              state <= ST_ADDR;
            else if (is_addr_wr && wr_ok)
              state <= ST_ADDR;
            else
              state <= ST_IGNORE;
          end
          ST_ADDR:
          begin
            addr    <= next_addr;
            bytecnt <= bytecnt + 2'h1;
            if (bytecnt == 2'h2)
            begin
              if (opcode == OP_READ_SLOW)
                state <= ST_READ;
              else if (opcode == OP_PROGRAM)
                state <= ST_PROG;
              else if (opcode == OP_READ_FAST || opcode == OP_READ_DUAL)
                state <= ST_DUMMY;
              else
                state <= ST_IGNORE;
            end
          end
          ST_DUMMY:
            state <= ST_READ;
          default:
            state <= state;
        endcase
      end
    end
    else if (sck_fall && state == ST_READ)
      bitcnt <= dual ? bitcnt + 3'h2 : bitcnt + 3'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data path

  // Shift only on falling edges so the host samples on the next rise
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SO                  <= 1'b0;
      DUAL_DATA_LOWER_BIT <= 1'b0;
      outbuf              <= 8'h00;
      ARR_RD_ADDR         <= '0;
    end
    else if (byte_done && state == ST_ADDR && bytecnt == 2'h2)
      ARR_RD_ADDR <= next_addr;
    else if (sck_fall && state == ST_READ)
    begin
      SO                  <= cur_byte[7];
      DUAL_DATA_LOWER_BIT <= cur_byte[6];
      outbuf              <= dual ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
      if (rd_last)
        ARR_RD_ADDR <= ARR_RD_ADDR + 17'h00001;
    end
  end

  // Output enables drop on the MCLK after deselect or hold is sampled
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SO_OE                  <= 1'b0;
      DUAL_DATA_LOWER_BIT_OE <= 1'b0;
    end
    else
    begin
      SO_OE                  <= run & (state == ST_READ);
      DUAL_DATA_LOWER_BIT_OE <= run & (state == ST_READ) & dual;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array program and erase

  // Program bytes wrap inside the 256-byte page
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ARR_WR         <= 1'b0;
      ARR_WR_ADDR    <= '0;
      ARR_WR_DATA    <= 8'h00;
      ARR_ERASE      <= 1'b0;
      ARR_ERASE_KIND <= ERASE_4K;
      ARR_ERASE_ADDR <= '0;
      pofs           <= 8'h00;
      pend_erase     <= 1'b0;
      pend_kind      <= ERASE_4K;
      prog_seen      <= 1'b0;
    end
    else
    begin
      ARR_WR    <= 1'b0;
      ARR_ERASE <= 1'b0;
      if (cs_start)
      begin
        pend_erase <= 1'b0;
        prog_seen  <= 1'b0;
      end
      else if (cs_end)
      begin
        ARR_ERASE      <= pend_erase;
        ARR_ERASE_KIND <= pend_kind;
        ARR_ERASE_ADDR <= align(addr, pend_kind);
        pend_erase     <= 1'b0;
        prog_seen      <= 1'b0;
      end
      else if (byte_done)
      begin
        if (state == ST_CMD && is_chip && wr_ok)
        begin
          pend_erase <= 1'b1;
          pend_kind  <= ERASE_CHIP;
        end
        else if (state == ST_ADDR && bytecnt == 2'h2)
        begin
          pend_erase <= opcode != OP_PROGRAM && !is_read_op(opcode);
          pend_kind  <= erase_kind(opcode);
          pofs       <= byte_in;
        end
        else if (state == ST_PROG)
        begin
          ARR_WR      <= 1'b1;
          ARR_WR_ADDR <= (addr & ~MASK_PAGE) | {9'h000, pofs};
          ARR_WR_DATA <= byte_in;
          pofs        <= pofs + 8'h01;
          prog_seen   <= 1'b1;
        end
      end
    end
  end

  function automatic logic is_read_op(input logic [7:0] op);
    return op == OP_READ_SLOW || op == OP_READ_FAST || op == OP_READ_DUAL;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Self-timed cycle and standby

  wire start_cycle = cs_end & (pend_erase | prog_seen);
  wire [BUSY_W-1:0] next_busy_cnt = start_cycle ? BUSY_W'(BUSY_CYCLES)
                                  : busy_now ? busy_cnt - 1'b1 : busy_cnt;

  // Counts down whatever the hold pin does
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      busy_cnt <= '0;
      BUSY     <= 1'b0;
      STANDBY  <= 1'b1;
    end
    else
    begin
      busy_cnt <= next_busy_cnt;
      BUSY     <= next_busy_cnt != '0;
      STANDBY  <= ~cs_act & (next_busy_cnt == '0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  sequence s_hold_pause;
    hold_act ##1 hold_act;
  endsequence

  property p_so_fall;
    $changed(SO) |-> $past(sck_fall);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("SO moved off a fall");

  property p_dual_fall;
    $changed(DUAL_DATA_LOWER_BIT) |-> $past(sck_fall) && $past(state == ST_READ);
  endproperty
  a_dual_fall: assert property (p_dual_fall) else $error("lower bit moved off a fall");

  property p_deselect_hiz;
    !cs_act |=> !SO_OE && !DUAL_DATA_LOWER_BIT_OE;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) else $error("driving while deselected");

  property p_hold_hiz;
    hold_act |=> !SO_OE && !DUAL_DATA_LOWER_BIT_OE;
  endproperty
  a_hold_hiz: assert property (p_hold_hiz) else $error("driving during hold");

  property p_hold_resume;
    s_hold_pause |-> bitcnt == $past(bitcnt) && state == $past(state);
  endproperty
  a_hold_resume: assert property (p_hold_resume) else $error("bit position moved in hold");

  property p_busy_runs;
    busy_now && !cs_end |=> busy_cnt == $past(busy_cnt) - 1'b1;
  endproperty
  a_busy_runs: assert property (p_busy_runs) else $error("self-timed count stalled");

  property p_wp_lock;
    byte_done && state == ST_CMD && wp_lock && !is_read && !cs_start && !cs_end
      |=> state == ST_IGNORE && !pend_erase;
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("locked write accepted");

  property p_erase_align;
    ARR_ERASE |-> (ARR_ERASE_KIND == ERASE_4K ? (ARR_ERASE_ADDR & MASK_4K) == '0
                   : (ARR_ERASE_ADDR & MASK_32K) == '0) ##1 BUSY;
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase misaligned");

  property p_dual_oe;
    DUAL_DATA_LOWER_BIT_OE |-> dual && SO_OE;
  endproperty
  a_dual_oe: assert property (p_dual_oe) else $error("lower line driven outside dual");

  property p_standby;
    STANDBY |-> !BUSY && $past(!cs_act);
  endproperty
  a_standby: assert property (p_standby) else $error("standby while busy");

  property p_capture;
    sck_rise && state == ST_CMD |=> shreg[0] == $past(si_bit);
  endproperty
  a_capture: assert property (p_capture) else $error("input not taken on rise");

endmodule // flash_pins_core

// *** bench/spi_host_model.sv ***
// Purpose: mode 0 SPI host that frames, shifts, pauses and samples bytes
// Assumes: called from the bench; every change lands on a rising MCLK edge
// Notes:   link clock stays low outside frames; SI released for dual data
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic  mclk,
  // Lines seen by the host
  input  wire logic  so_pin,
  input  wire logic  si_pin,
  // Lines driven by the host
  output logic       cs_n,
  output logic       sck,
  output logic       si_out,
  output logic       si_oe,
  output logic       hold_low,
  // Received bytes
  output logic [7:0] rx_data,
  output logic [7:0] rx_cnt
);
  localparam int HALF = 10; // Half of the 160 ns link period

  int n_rx = 0; // Bytes reported so far

  assign rx_cnt = 8'(n_rx);

  // Idle pins at time zero: deselected, clock low, hold released
  initial
  begin
    {cs_n, sck, si_out, si_oe, hold_low} = 5'h10;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic set_pins(input logic c, input logic h);
    cs_n     <= c;
    hold_low <= h;
  endtask

  // Select, with margin for the pin synchroniser
  task automatic frame_start();
    wait_clk(1);
    si_oe <= 1'b1;
    cs_n  <= 1'b0;
    wait_clk(4);
  endtask

  // SI is taken back only at the next select, once the device has let go
  task automatic frame_end();
    wait_clk(2);
    cs_n  <= 1'b1;
    wait_clk(6);
  endtask

  // Mode: bit0 report byte, bit1 dual, bit2 release SI after last rise
  task automatic xfer(input logic [7:0] tx, input logic [2:0] mode, input int hold_at);
    logic [7:0] rx;
    int         n;
    rx = 8'h00;
    n  = mode[1] ? 4 : 8;
    for (int i = 0; i < n; i++)
    begin
      if (i == hold_at)
      begin
        // Pause with the clock low, then wiggle clock and data meanwhile
        wait_clk(6);
        hold_low <= 1'b1;
        wait_clk(HALF);
        sck    <= 1'b1;
        si_out <= ~si_out;
        wait_clk(HALF);
        sck <= 1'b0;
        wait_clk(HALF);
        hold_low <= 1'b0;
        wait_clk(6);
      end
      si_out <= tx[7 - i];
      wait_clk(HALF);
      sck <= 1'b1;
      rx = mode[1] ? {rx[5:0], so_pin, si_pin} : {rx[6:0], so_pin};
      if (i == n - 1 && mode[2])
        si_oe <= 1'b0;
      wait_clk(HALF);
      sck <= 1'b0;
    end
    if (mode[0])
    begin
      rx_data <= rx;
      n_rx    <= n_rx + 1;
    end
  endtask
endmodule // spi_host_model

// *** bench/serial_flash_pins_hold_array_bench.sv ***
// Purpose: self-checking bench for the serial flash pin engine
// Assumes: array modelled as a pure function of the read address
// Notes:   notes queue pairs expected array events and read bytes in order
`timescale 1ns/1ps
module serial_flash_pins_hold_array_bench;
  import flash_pins_pkg::*;
  localparam int BC = 20; // Short self-timed cycle

  logic        mclk, rstn, wp_low, so, so_oe, lo_bit, lo_oe;
  logic        arr_wr, arr_erase, busy, standby, cs_n, sck, si_out, si_oe, hold_low;
  logic [16:0] rd_addr, wr_addr, erase_addr, a;
  logic [7:0]  rd_data, wr_data, rx_data, rx_cnt, seen_cnt, d, op;
  logic [1:0]  erase_kind;
  logic [26:0] exp_q[$];
  logic [7:0]  ops[6] = '{OP_ERASE_4K, OP_ERASE_32A, OP_ERASE_32B, OP_CHIP_A, OP_CHIP_B, OP_CHIP_C};
  int          n_mismatch, cmp_count, seed, quiet;
  wire         so_w, si_w, hold_w, wp_w;

  // Pin wires with pull-ups, released lines float high
  assign so_w   = so_oe ? so : 1'bz;
  assign si_w   = si_oe ? si_out : (lo_oe ? lo_bit : 1'bz);
  assign hold_w = hold_low ? 1'b0 : 1'bz;
  assign wp_w   = wp_low ? 1'b0 : 1'bz;
  pullup (so_w);
  pullup (si_w);
  pullup (hold_w);
  pullup (wp_w);

  function automatic logic [7:0] mem_byte(input logic [16:0] x);
    return x[7:0] ^ x[15:8] ^ {7'h00, x[16]} ^ 8'h3c;
  endfunction
  assign rd_data = mem_byte(rd_addr);

  ////////////////////////////////////////////////////////////////////////////
  flash_pins_core #(.BUSY_CYCLES(BC)) dut (
    .MCLK(mclk), .RSTN(rstn), .CS_N(cs_n), .SCK(sck), .SI(si_w), .WP_N(wp_w),
    .HOLD_N(hold_w), .SO(so), .SO_OE(so_oe), .DUAL_DATA_LOWER_BIT(lo_bit),
    .DUAL_DATA_LOWER_BIT_OE(lo_oe), .ARR_RD_ADDR(rd_addr), .ARR_RD_DATA(rd_data),
    .ARR_WR(arr_wr), .ARR_WR_ADDR(wr_addr), .ARR_WR_DATA(wr_data),
    .ARR_ERASE(arr_erase), .ARR_ERASE_KIND(erase_kind), .ARR_ERASE_ADDR(erase_addr),
    .BUSY(busy), .STANDBY(standby));

  spi_host_model host (
    .mclk(mclk), .so_pin(so_w), .si_pin(si_w), .cs_n(cs_n), .sck(sck),
    .si_out(si_out), .si_oe(si_oe), .hold_low(hold_low), .rx_data(rx_data),
    .rx_cnt(rx_cnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("TB: cmp_count=%0d n_mismatch=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic note(input logic [1:0] k, input logic [16:0] x, input logic [7:0] v);
    exp_q.push_back({k, x, v});
  endtask

  task automatic take(input logic [26:0] got);
    check(exp_q.size() > 0 && exp_q.pop_front() === got, $sformatf("event %h", got));
  endtask

  task automatic send_cmd(input logic [7:0] c, input logic [16:0] x);
    host.frame_start();
    host.xfer(c, 3'h0, -1);
    host.xfer({7'h2a, x[16]}, 3'h0, -1); // Upper bits are ignored
    host.xfer(x[15:8], 3'h0, -1);
    host.xfer(x[7:0], 3'h0, -1);
  endtask

  // Hold and select during the self-timed cycle; it must still end on time
  task automatic busy_wait();
    int n;
    n = 0;
    check(busy === 1'b1 && standby === 1'b0, "busy/standby at cycle start");
    host.set_pins(1'b0, 1'b0);
    host.wait_clk(4);
    host.set_pins(1'b0, 1'b1);
    while (busy !== 1'b0 && n < 200)
    begin
      host.wait_clk(1);
      n++;
    end
    check(n >= BC - 12 && n <= BC, "self-timed length");
    host.set_pins(1'b1, 1'b0);
    host.wait_clk(6);
    check(standby === 1'b1, "standby after cycle");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: array events, read bytes, tri-state while paused or deselected
  always @(posedge mclk)
  begin
    if (arr_wr === 1'b1)
      take({2'h1, wr_addr, wr_data});
    if (arr_erase === 1'b1)
      take({2'h2, erase_addr, 6'h00, erase_kind});
    if (rx_cnt !== seen_cnt)
    begin
      seen_cnt <= rx_cnt;
      take({2'h3, 17'h0, rx_data});
    end
    quiet = (hold_w === 1'b0 || cs_n === 1'b1) ? quiet + 1 : 0;
    if (quiet == 6)
      check(so_oe === 1'b0 && lo_oe === 1'b0, "outputs driven while idle");
  end

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    host.wait_clk(100000);
    n_mismatch++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    finish_test();
  end

  // Main sequence
  initial
  begin
    {rstn, wp_low, n_mismatch, cmp_count, quiet, seed, seen_cnt} = {2'b00, 32'd0, 32'd0, 32'd0, 32'd20, 8'h00};
    host.wait_clk(12);
    rstn <= 1'b1;
    host.wait_clk(4);
    // Slow read wrapping past the last array byte
    send_cmd(OP_READ_SLOW, 17'h1fffe);
    for (int i = 0; i < 3; i++)
    begin
      note(2'h3, 17'h0, mem_byte(17'h1fffe + 17'(i)));
      host.xfer(8'h00, 3'h1, -1);
    end
    host.frame_end();
    // Fast read paused mid-byte with stray clock and data edges
    send_cmd(OP_READ_FAST, 17'h0a5f0);
    host.xfer(8'h00, 3'h0, -1);
    note(2'h3, 17'h0, mem_byte(17'h0a5f0));
    note(2'h3, 17'h0, mem_byte(17'h0a5f1));
    host.xfer(8'h00, 3'h1, 3);
    host.xfer(8'h00, 3'h1, -1);
    host.frame_end();
    // Dual read: two bits on every falling edge
    send_cmd(OP_READ_DUAL, 17'h00123);
    host.xfer(8'h00, 3'h4, -1);
    note(2'h3, 17'h0, mem_byte(17'h00123));
    note(2'h3, 17'h0, mem_byte(17'h00124));
    host.xfer(8'h00, 3'h3, -1);
    host.xfer(8'h00, 3'h3, -1);
    host.frame_end();
    // Protected: program and erase refused
    wp_low <= 1'b1;
    send_cmd(OP_PROGRAM, 17'h00040);
    host.xfer(8'h5a, 3'h0, -1);
    host.frame_end();
    send_cmd(OP_ERASE_32A, 17'h08000);
    host.frame_end();
    check(busy === 1'b0, "cycle started while protected");
    wp_low <= 1'b0;
    // Floating protect: program wraps inside its page
    send_cmd(OP_PROGRAM, 17'h001fe);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($random(seed));
      note(2'h1, {9'h001, 8'hfe + 8'(i)}, d);
      host.xfer(d, 3'h0, -1);
    end
    host.frame_end();
    busy_wait();
    // Every erase opcode; sector erases take a random address, chip erases none
    for (int k = 0; k < 6; k++)
    begin
      op = ops[k];
      a  = 17'($random(seed)) & ARRAY_LAST;
      if (k < 3)
        note(2'h2, a & ~(k == 0 ? MASK_4K : MASK_32K), k == 0 ? 8'h00 : 8'h01);
      else
        note(2'h2, 17'h0, 8'h02);
      if (k < 3)
        send_cmd(op, a);
      else
      begin
        host.frame_start();
        host.xfer(op, 3'h0, -1);
      end
      host.frame_end();
      busy_wait();
    end
    host.wait_clk(10);
    check(exp_q.size() == 0, "expected events missing");
    finish_test();
  end
endmodule // serial_flash_pins_hold_array_bench
